// file: src/orpt_pkg.sv
package orpt_pkg;
	// Link command that reads the parameter words (value arbitrary)
	localparam logic [7:0]  ORPT_READ_OPCODE    = 8'ha5;
	localparam int          ORPT_CMD_BITS       = 8;
	localparam int          ORPT_ADDR_BITS      = 24;
	localparam int          ORPT_DUMMY_CLKS     = 8;
	// Byte offsets of the two words inside the table
	localparam logic [23:0] ORPT_FAST_READ_OFS  = 24'h000000;
	localparam logic [23:0] ORPT_DTR_OFS        = 24'h000004;
	localparam logic [23:0] ORPT_TABLE_BYTES    = 24'h000008;
	// Field positions of the fast read word
	localparam int          ORPT_OP118_LSB      = 24;
	localparam int          ORPT_MODE118_LSB    = 21;
	localparam int          ORPT_DUMMY118_LSB   = 16;
	localparam int          ORPT_OP188_LSB      = 8;
	localparam int          ORPT_MODE188_LSB    = 5;
	localparam int          ORPT_DUMMY188_LSB   = 0;
	// Field positions of the double rate word
	localparam int          ORPT_BYTE_SWAP_BIT  = 31;
	localparam int          ORPT_CMD_EXT_LSB    = 29;
	localparam int          ORPT_RSVD_BIT       = 28;
	localparam int          ORPT_STRB_DBL_BIT   = 27;
	localparam int          ORPT_STRB_SGL_BIT   = 26;
	localparam int          ORPT_STRB_WAVE_LSB  = 24;
	localparam int          ORPT_INBAND_RST_BIT = 23;
	localparam int          ORPT_DRV_LSB        = 18;
	localparam int          ORPT_RSVD_LOW_BITS  = 18;
	// Field values reported after reset
	localparam logic [7:0]  ORPT_OP118_VAL      = 8'h11;
	localparam logic [2:0]  ORPT_MODE118_VAL    = 3'h0;
	localparam logic [4:0]  ORPT_DUMMY118_VAL   = 5'h08;
	localparam logic [7:0]  ORPT_OP188_VAL      = 8'h22;
	localparam logic [2:0]  ORPT_MODE188_VAL    = 3'h1;
	localparam logic [4:0]  ORPT_DUMMY188_VAL   = 5'h02;
	localparam logic        ORPT_BYTE_SWAP_VAL  = 1'h0;
	localparam logic [1:0]  ORPT_CMD_EXT_VAL    = 2'h1;
	localparam logic        ORPT_STRB_DBL_VAL   = 1'h1;
	localparam logic        ORPT_STRB_SGL_VAL   = 1'h1;
	localparam logic [1:0]  ORPT_STRB_WAVE_VAL  = 2'h3;
	localparam logic        ORPT_INBAND_RST_VAL = 1'h1;
	localparam logic [4:0]  ORPT_DRV_VAL        = 5'h01;
	// Encodings
	localparam logic [1:0]  ORPT_CMD_EXT_RSVD   = 2'h2;
	localparam logic [1:0]  ORPT_STRB_WAVE_RSVD = 2'h0;
	localparam logic [4:0]  ORPT_DRV_TYPE0      = 5'h01;

	typedef enum {
		ORPT_IDLE,
		ORPT_CMD,
		ORPT_ADDR,
		ORPT_DUMMY,
		ORPT_DATA,
		ORPT_IGNORE
	} orpt_state_t;
endpackage

// file: src/orpt_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface orpt_link_if;
	logic serial_clock_s;
	logic cs_n_s;
	logic si_s;
	modport sync (output serial_clock_s, output cs_n_s, output si_s);
	modport core (input serial_clock_s, input cs_n_s, input si_s);
endinterface
`default_nettype wire

// file: src/orpt_sync.sv
`timescale 1ns/10ps
`default_nettype none
module orpt_sync
	import orpt_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    reset_n,
	input  wire logic    serial_clock,
	input  wire logic    cs_n,
	input  wire logic    si,
	orpt_link_if.sync    link
);
	logic [2:0] meta_r;
	logic [2:0] stable_r;

	// Chip select idles high so the table starts deselected
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r   <= 3'h2;
			stable_r <= 3'h2;
		end else begin
			meta_r   <= {si, cs_n, serial_clock};
			stable_r <= meta_r;
		end
	end

	assign link.serial_clock_s = stable_r[0];
	assign link.cs_n_s         = stable_r[1];
	assign link.si_s           = stable_r[2];
endmodule
`default_nettype wire

// file: src/orpt_shift_in.sv
`timescale 1ns/10ps
`default_nettype none
module orpt_shift_in
	import orpt_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             clear,
	input  wire logic             shift_en,
	input  wire logic             bit_in,
	output logic [WIDTH-1:0]      value
);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			value <= '0;
		end else if (clear) begin
			value <= '0;
		end else if (shift_en) begin
			value <= {value[WIDTH-2:0], bit_in};
		end
	end
endmodule
`default_nettype wire

// file: src/orpt_octal_read_param_table.sv
// Behaviour
// RULE_01: Top byte of word 17: 1-1-8 opcode.
// RULE_02: Three-bit 1-1-8 mode clock count.
// RULE_03: Five-bit 1-1-8 dummy clock count.
// RULE_04: Host drives mode clocks, releases during dummy.
// RULE_05: Reported dummy count should exceed zero.
// RULE_06: Second byte of word 17: 1-8-8 opcode.
// RULE_07: Three-bit 1-8-8 mode clock count.
// RULE_08: Lowest five bits: 1-8-8 dummy count.
// RULE_09: Top bit of word 18: byte swap.
// RULE_10: Two-bit command extension style code.
// RULE_11: Strobe flag for four-line double rate.
// RULE_12: Strobe flag for four-line single rate.
// RULE_13: Code 11b: strobe rises before data.
// RULE_14: Codes 10b and 01b waveforms; 00b reserved.
// RULE_15: One bit flags in-band protocol reset.
// RULE_16: Five-bit supported driver type mask.
// RULE_17: Reserved bit 28 and bits 17:0 zero.
// RULE_18: Host avoids reserved extension and waveform codes.
`timescale 1ns/10ps
`default_nettype none
module orpt_octal_read_param_table
	import orpt_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    reset_n,
	input  wire logic    serial_clock,
	input  wire logic    cs_n,
	input  wire logic    si,
	output logic         so_out,
	output logic         so_oe,
	output logic [31:0]  fast_read_word,
	output logic [31:0]  dtr_word
);
	orpt_link_if link ();

	orpt_sync u_sync (
		.clk          (clk),
		.reset_n      (reset_n),
		.serial_clock (serial_clock),
		.cs_n         (cs_n),
		.si           (si),
		.link         (link)
	);

	logic              sclk_prev_r;
	logic              sclk_rise;
	logic              sclk_fall;
	logic              selected;
	orpt_state_t       state_r;
	logic [4:0]        bit_cnt_r;
	logic [23:0]       addr_r;
	logic [7:0]        out_byte_r;
	logic [7:0]        out_byte_nxt;
	logic [31:0]       fast_read_r;
	logic [31:0]       dtr_r;
	logic [31:0]       word_sel;
	logic [23:0]       in_value;
	logic              shift_clear;

	assign fast_read_word = fast_read_r;
	assign dtr_word       = dtr_r;
	assign selected       = !link.cs_n_s;
	assign sclk_rise      = link.serial_clock_s && !sclk_prev_r;
	assign sclk_fall      = !link.serial_clock_s && sclk_prev_r;
	assign shift_clear    = !selected || (state_r == ORPT_IDLE);

	// Edges are found on the synchronised copy, a few clk behind the pin
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_prev_r <= 1'h0;
		end else begin
			sclk_prev_r <= link.serial_clock_s;
		end
	end

	orpt_shift_in #(
		.WIDTH (24)
	) u_shift_in (
		.clk      (clk),
		.reset_n  (reset_n),
		.clear    (shift_clear),
		.shift_en (selected && sclk_rise),
		.bit_in   (link.si_s),
		.value    (in_value)
	);

	// Table words, zero in reset and fixed once reset is released
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fast_read_r <= 32'h0;
			dtr_r       <= 32'h0;
		end else begin
			fast_read_r <= 32'h0;
			// RULE_01: 1-1-8 opcode field
			fast_read_r[ORPT_OP118_LSB +: 8] <= ORPT_OP118_VAL;
			// RULE_02: 1-1-8 mode clocks
			fast_read_r[ORPT_MODE118_LSB +: 3] <= ORPT_MODE118_VAL;
			// RULE_03: 1-1-8 dummy clocks
			fast_read_r[ORPT_DUMMY118_LSB +: 5] <= ORPT_DUMMY118_VAL;
			// RULE_06: 1-8-8 opcode field
			fast_read_r[ORPT_OP188_LSB +: 8] <= ORPT_OP188_VAL;
			// RULE_07: 1-8-8 mode clocks
			fast_read_r[ORPT_MODE188_LSB +: 3] <= ORPT_MODE188_VAL;
			// RULE_08: 1-8-8 dummy clocks
			fast_read_r[ORPT_DUMMY188_LSB +: 5] <= ORPT_DUMMY188_VAL;
			// RULE_17: reserved bits stay zero
			dtr_r <= 32'h0;
			// RULE_09: byte order flag
			dtr_r[ORPT_BYTE_SWAP_BIT] <= ORPT_BYTE_SWAP_VAL;
			// RULE_10: command extension code
			dtr_r[ORPT_CMD_EXT_LSB +: 2] <= ORPT_CMD_EXT_VAL;
			// RULE_11: strobe in double rate
			dtr_r[ORPT_STRB_DBL_BIT] <= ORPT_STRB_DBL_VAL;
			// RULE_12: strobe in single rate
			dtr_r[ORPT_STRB_SGL_BIT] <= ORPT_STRB_SGL_VAL;
			// RULE_13: waveform code field
			// RULE_14: waveform code field
			dtr_r[ORPT_STRB_WAVE_LSB +: 2] <= ORPT_STRB_WAVE_VAL;
			// RULE_15: in-band reset flag
			dtr_r[ORPT_INBAND_RST_BIT] <= ORPT_INBAND_RST_VAL;
			// RULE_16: driver type mask
			dtr_r[ORPT_DRV_LSB +: 5] <= ORPT_DRV_VAL;
		end
	end

	// Little-endian byte pick; addresses past the table read zero
	always_comb begin
		word_sel     = (addr_r[23:2] == ORPT_DTR_OFS[23:2]) ? dtr_r : fast_read_r;
		out_byte_nxt = 8'h0;
		if (addr_r < ORPT_TABLE_BYTES) begin
			out_byte_nxt = word_sel[{addr_r[1:0], 3'h0} +: 8];
		end
	end

	// Link sequencing: command, address, dummy clocks, then data
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r   <= ORPT_IDLE;
			bit_cnt_r <= 5'h0;
			addr_r    <= 24'h0;
		end else if (!selected) begin
			state_r   <= ORPT_IDLE;
			bit_cnt_r <= 5'h0;
		end else begin
			case (state_r)
				ORPT_IDLE: begin
					state_r   <= ORPT_CMD;
					bit_cnt_r <= 5'h0;
				end
				ORPT_CMD: begin
					if (sclk_rise) begin
						bit_cnt_r <= bit_cnt_r + 5'h1;
						if (bit_cnt_r == 5'(ORPT_CMD_BITS - 1)) begin
							bit_cnt_r <= 5'h0;
							if ({in_value[6:0], link.si_s} == ORPT_READ_OPCODE) begin
								state_r <= ORPT_ADDR;
							end else begin
								state_r <= ORPT_IGNORE;
							end
						end
					end
				end
				ORPT_ADDR: begin
					if (sclk_rise) begin
						bit_cnt_r <= bit_cnt_r + 5'h1;
						if (bit_cnt_r == 5'(ORPT_ADDR_BITS - 1)) begin
							bit_cnt_r <= 5'h0;
							addr_r    <= {in_value[22:0], link.si_s};
							state_r   <= ORPT_DUMMY;
						end
					end
				end
				// RULE_04: host owns the line while we wait
				ORPT_DUMMY: begin
					if (sclk_rise) begin
						bit_cnt_r <= bit_cnt_r + 5'h1;
						if (bit_cnt_r == 5'(ORPT_DUMMY_CLKS - 1)) begin
							bit_cnt_r <= 5'h0;
							state_r   <= ORPT_DATA;
						end
					end
				end
				ORPT_DATA: begin
					if (sclk_fall) begin
						bit_cnt_r <= (bit_cnt_r == 5'h7) ? 5'h0 : bit_cnt_r + 5'h1;
						if (bit_cnt_r == 5'h7) begin
							addr_r <= addr_r + 24'h1;
						end
					end
				end
				ORPT_IGNORE: begin
					state_r <= ORPT_IGNORE;
				end
				default: begin
					state_r <= ORPT_IDLE;
				end
			endcase
		end
	end

	// Output shifter; bits change on falling edges, MSB first
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_byte_r <= 8'h0;
			so_out     <= 1'h0;
		end else if (state_r == ORPT_DATA && sclk_fall) begin
			so_out     <= (bit_cnt_r == 5'h0) ? out_byte_nxt[7] : out_byte_r[7];
			out_byte_r <= (bit_cnt_r == 5'h0) ? {out_byte_nxt[6:0], 1'h0} : {out_byte_r[6:0], 1'h0};
		end
	end

	// RULE_05: drive only after the dummy clocks, never against the host
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			so_oe <= 1'h0;
		end else if (!selected || state_r != ORPT_DATA) begin
			so_oe <= 1'h0;
		end else if (sclk_fall) begin
			so_oe <= 1'h1;
		end
	end

	// Checks
	sequence data_fall_s;
		state_r == ORPT_DATA && selected && sclk_fall;
	endsequence

	sequence first_bit_s;
		data_fall_s ##0 bit_cnt_r == 5'h0;
	endsequence

	property opcode_fields_p;
		@(posedge clk) disable iff (!reset_n)
		$rose(reset_n) |-> ##1 fast_read_r[31:24] == ORPT_OP118_VAL && fast_read_r[15:8] == ORPT_OP188_VAL;
	endproperty

	word17_opcodes_a: assert property (opcode_fields_p) else $error("opcode fields wrong"); // RULE_01 RULE_06

	mode_counts_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_02 RULE_07
		$past(reset_n) |-> fast_read_r[23:21] == ORPT_MODE118_VAL && fast_read_r[7:5] == ORPT_MODE188_VAL)
		else $error("mode clock fields wrong");

	dummy_nonzero_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03 RULE_05 RULE_08
		$past(reset_n) && fast_read_r[31:24] != 8'h0 && fast_read_r[15:8] != 8'h0
		|-> fast_read_r[20:16] == ORPT_DUMMY118_VAL && fast_read_r[4:0] == ORPT_DUMMY188_VAL
		&& fast_read_r[20:16] != 5'h0 && fast_read_r[4:0] != 5'h0)
		else $error("dummy clock fields wrong");

	dtr_codes_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_09 RULE_10
		$past(reset_n) |-> dtr_r[31] == ORPT_BYTE_SWAP_VAL && dtr_r[30:29] != ORPT_CMD_EXT_RSVD)
		else $error("byte order or extension code wrong");

	strobe_flags_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11 RULE_12 RULE_13 RULE_14
		$past(reset_n) |-> dtr_r[27:26] == {ORPT_STRB_DBL_VAL, ORPT_STRB_SGL_VAL}
		&& dtr_r[25:24] != ORPT_STRB_WAVE_RSVD)
		else $error("strobe fields wrong");

	driver_reset_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_15 RULE_16
		$past(reset_n) |-> dtr_r[23] == ORPT_INBAND_RST_VAL && (dtr_r[22:18] & ORPT_DRV_TYPE0) != 5'h0)
		else $error("reset flag or driver mask wrong");

	reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_17
		dtr_r[ORPT_RSVD_BIT] == 1'h0 && dtr_r[ORPT_RSVD_LOW_BITS-1:0] == 18'h0)
		else $error("reserved bits not zero");

	no_drive_dummy_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04 RULE_05
		state_r == ORPT_DUMMY |=> !so_oe)
		else $error("output driven during dummy clocks");

	first_bit_out_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
		first_bit_s |=> so_oe && so_out == $past(out_byte_nxt[7]))
		else $error("first data bit wrong");

	// Link phase checks
	sequence dummy_last_s;
		state_r == ORPT_DUMMY && selected && sclk_rise ##0 bit_cnt_r == 5'(ORPT_DUMMY_CLKS - 1);
	endsequence

	sequence byte_end_s;
		data_fall_s ##0 bit_cnt_r == 5'h7;
	endsequence

	dummy_to_data_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04 RULE_05
		dummy_last_s |=> state_r == ORPT_DATA && !so_oe)
		else $error("data phase entered at the wrong time");

	deselect_quiet_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
		!selected |=> !so_oe)
		else $error("output enabled while deselected");

	refused_quiet_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
		state_r == ORPT_IGNORE |=> !so_oe)
		else $error("output enabled after a refused command");

	out_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
		!(state_r == ORPT_DATA && sclk_fall) |=> $stable(so_out))
		else $error("output bit moved outside a data fall");

	// Words load at the first edge, so stability is only owed from the third
	words_fixed_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_17
		$past(reset_n, 2) && $past(reset_n) |-> $stable(fast_read_r) && $stable(dtr_r))
		else $error("parameter words changed after load");

	byte_step_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01 RULE_09
		byte_end_s |=> addr_r == $past(addr_r) + 24'h1 && bit_cnt_r == 5'h0)
		else $error("byte address did not step");
endmodule
`default_nettype wire

// file: dv/orpt_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module orpt_host_model (
	input  wire logic clk,
	output logic      serial_clock,
	output logic      cs_n,
	output logic      si,
	input  wire logic so_out,
	input  wire logic so_oe
);
	logic [7:0] rx_q [$];
	int         oe_cnt;

	// Link clock stands low between frames
	initial begin
		serial_clock = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// Half of the 160 ns link period
	task automatic half();
		repeat (16) @(negedge clk);
	endtask

	task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nbytes);
		logic [31:0] hdr;
		logic [7:0]  sh;
		hdr = {op, addr};
		sh = 8'h00;
		oe_cnt = 0;
		rx_q.delete();
		cs_n = 1'b0;
		for (int k = 0; k < 40 + 8 * nbytes; k++) begin
			si = (k < 32) ? hdr[31 - k] : ~si;
			half();
			oe_cnt += int'(so_oe === 1'b1);
			if (k >= 40) begin
				sh = {sh[6:0], so_out};
				if (k % 8 == 7)
					rx_q.push_back(sh);
			end
			serial_clock = 1'b1;
			half();
			serial_clock = 1'b0;
		end
		half();
		cs_n = 1'b1;
		// Released line must not keep the last value
		si = ~si;
	endtask
endmodule
`default_nettype wire

// file: dv/orpt_octal_read_param_table_tb.sv
`timescale 1ns/10ps
`default_nettype none
module orpt_octal_read_param_table_tb
	import orpt_pkg::*;
;
	logic        clk;
	logic        reset_n;
	logic        serial_clock;
	logic        cs_n;
	logic        si;
	logic        so_out;
	logic        so_oe;
	logic [31:0] fast_read_word;
	logic [31:0] dtr_word;
	logic [63:0] all_w;
	logic [7:0]  exp_b [0:11];
	int          error_cnt;
	int          compares;

	orpt_octal_read_param_table dut_u (
		.clk            (clk),
		.reset_n        (reset_n),
		.serial_clock   (serial_clock),
		.cs_n           (cs_n),
		.si             (si),
		.so_out         (so_out),
		.so_oe          (so_oe),
		.fast_read_word (fast_read_word),
		.dtr_word       (dtr_word)
	);

	orpt_host_model host_u (
		.clk          (clk),
		.serial_clock (serial_clock),
		.cs_n         (cs_n),
		.si           (si),
		.so_out       (so_out),
		.so_oe        (so_oe)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Refused commands must never enable the output
	task automatic read_check(input logic [7:0] op, input logic [23:0] addr, input int n);
		host_u.frame(op, addr, n);
		check("oe bits", host_u.oe_cnt, (op === ORPT_READ_OPCODE) ? 8 * n : 0);
		for (int i = 0; i < n; i++)
			if (op === ORPT_READ_OPCODE)
				check("link byte", host_u.rx_q[i], exp_b[addr + i]);
		repeat (8) @(negedge clk);
		check("oe after frame", so_oe, 1'b0);
	endtask

	initial begin
		reset_n = 1'b0;
		all_w = {ORPT_BYTE_SWAP_VAL, ORPT_CMD_EXT_VAL, 1'b0, ORPT_STRB_DBL_VAL, ORPT_STRB_SGL_VAL,
			ORPT_STRB_WAVE_VAL, ORPT_INBAND_RST_VAL, ORPT_DRV_VAL, 18'h0,
			ORPT_OP118_VAL, ORPT_MODE118_VAL, ORPT_DUMMY118_VAL, ORPT_OP188_VAL, ORPT_MODE188_VAL,
			ORPT_DUMMY188_VAL};
		for (int i = 0; i < 12; i++)
			exp_b[i] = (i < 8) ? all_w[8 * i +: 8] : 8'h00;
		repeat (16) @(negedge clk);
		check("word17 in reset", fast_read_word, 32'h0);
		reset_n = 1'b1;
		repeat (8) @(negedge clk);
		check("word17", fast_read_word, all_w[31:0]);
		check("word18", dtr_word, all_w[63:32]);
		check("mode188", fast_read_word[7:5], 3'h1);
		check("dummy188", fast_read_word[4:0], 5'h02);
		check("dummy118 nonzero", |fast_read_word[20:16], 1'b1);
		check("cmd ext code", dtr_word[30:29] === ORPT_CMD_EXT_RSVD, 1'b0);
		check("wave code", dtr_word[25:24] === ORPT_STRB_WAVE_RSVD, 1'b0);
		check("driver type0", dtr_word[18], 1'b1);
		check("reserved bits", {dtr_word[28], dtr_word[17:0]}, 19'h0);
		read_check(ORPT_READ_OPCODE, ORPT_FAST_READ_OFS, 8);
		read_check(ORPT_READ_OPCODE, 24'h000006, 4);
		read_check(~ORPT_READ_OPCODE, ORPT_DTR_OFS, 2);
		// Second reset in mid-run
		reset_n = 1'b0;
		repeat (4) @(negedge clk);
		check("word18 in reset", dtr_word, 32'h0);
		reset_n = 1'b1;
		repeat (8) @(negedge clk);
		check("word18 again", dtr_word, all_w[63:32]);
		read_check(ORPT_READ_OPCODE, ORPT_DTR_OFS, 4);
		wrap_up();
	end

	// Frames need about 50 us; a hang is cut short well after that
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
endmodule
`default_nettype wire
